// ### shared/csci_pkg.sv
// Package for the channel setup command interpreter: codes, limits, carriers.
// Assumes one clock domain; all users import csci_pkg::*.
package csci_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_W = 3;
  localparam int DAC_W = 12;
  localparam int BIAS_W = 12;
  localparam logic [4:0] EXCITATION_CURRENT_LEVEL_MAX = 5'h14;
  localparam logic [3:0] MODE_CHARGE = 4'h0;
  localparam logic [3:0] MODE_VOLT = 4'h1;
  localparam logic [3:0] MODE_CCS = 4'h2;
  localparam logic [3:0] MODE_ISO_CCS = 4'h6;
  localparam logic [3:0] MODE_MAX = 4'h9;
  localparam logic [3:0] MODE_DEF = 4'h2;
  localparam logic [4:0] EXCITATION_CURRENT_LEVEL_DEF = 5'h04;
  localparam logic [2:0] CPL_AC = 3'h0;
  localparam logic [2:0] CPL_DC = 3'h1;
  localparam logic [2:0] CPL_UP = 3'h2;
  localparam logic [2:0] CPL_DOWN = 3'h3;
  localparam logic [2:0] CPL_LEAVE = 3'h4;
  localparam logic [1:0] OSC_MAX = 2'h2;
  localparam logic [2:0] FAULT_NONE = 3'h7;
  localparam logic [DAC_W-1:0] DAC_MID = 12'h800;
  localparam logic [7:0] APP_BYTES = 8'h08;
  localparam logic [7:0] MEM_BYTES = 8'h20;
  localparam logic [7:0] DESC_MAX = 8'h28;

  typedef enum logic [3:0] {
    CSCI_OP_INPUT_MODE, CSCI_OP_EXCITATION, CSCI_OP_IN_FILTER, CSCI_OP_OUT_FILTER,
    CSCI_OP_LIMIT, CSCI_OP_COUPLING, CSCI_OP_TONE, CSCI_OP_DESC_READ,
    CSCI_OP_COMBINED, CSCI_OP_BIAS, CSCI_OP_STATUS, CSCI_OP_OTHER
  } csci_op_t;

  typedef enum logic [3:0] {
    CSCI_OK = 4'h0, CSCI_E_OPTION = 4'h1, CSCI_E_CHANNEL = 4'h2, CSCI_E_COMMAND = 4'h3,
    CSCI_E_UNIT = 4'h4, CSCI_E_FUNCTION = 4'h5, CSCI_E_PARAM = 4'h6
  } csci_err_t;

  // One parsed command from the line front end
  typedef struct packed {
    logic [7:0] unit;
    logic [CH_W-1:0] chan;
    csci_op_t op;
    logic query;
    logic has_value;
    logic [7:0] value;
  } csci_cmd_t;

  // Answer descriptor handed to the text formatter
  typedef struct packed {
    logic [7:0] unit;
    csci_op_t op;
    csci_err_t err;
    logic [CH_W-1:0] chan;
    logic [7:0] value;
    logic all_chan;
  } csci_rsp_t;

  typedef struct packed {
    logic [3:0] mode;
    logic in_filt;
    logic out_filt;
    logic limit;
    logic [2:0] coupling;
    logic [1:0] tone;
  } csci_chan_t;
endpackage

// ### core/csci_offset_trim.sv
// One channel's offset DAC: zeroing load, manual trim, non-volatile keep.
// Assumes bias samples are valid when zero_load pulses.
module csci_offset_trim
  import csci_pkg::*;
#(
  parameter int W = DAC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restore,
  input wire logic [W-1:0] saved_value,
  input wire logic zero_load,
  input wire logic [W-1:0] bias,
  input wire logic step_up,
  input wire logic step_down,
  output logic [W-1:0] dac_q
);
  logic [W-1:0] dac_d;

  always_comb begin
    dac_d = dac_q;
    if (restore) begin
      dac_d = saved_value;
    end else if (zero_load) begin
      dac_d = W'(DAC_MID - bias + DAC_MID);
    end else if (step_up && dac_q != {W{1'b1}}) begin
      dac_d = W'(dac_q + 1'b1);
    end else if (step_down && dac_q != '0) begin
      dac_d = W'(dac_q - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_q <= DAC_MID;
    end else begin
      dac_q <= dac_d;
    end
  end
endmodule

// ### core/csci_interp.sv
// Command interpreter core: applies parsed commands, keeps channel state, forms answers.
// Assumes a text front end delivers csci_cmd_t and renders csci_rsp_t; APB control regs.
// Notes on behaviour
// - Input mode accepts codes 0 through 9 per channel.
// - Excitation is unit-wide, integer milliamps 0 to 20.
// - Excitation above zero moves voltage-mode channels to current-sensor mode.
// - Excitation zero moves current-sensor channels to voltage mode.
// - Unit-wide queries answer with the board's lowest channel number.
// - Input and output filter take 0 or 1 and read back the same.
// - Clamp takes 0 for buffered or 1 for enabled.
// - Coupling codes: AC, DC, trim up, trim down, leave trim.
// - AC to DC zeroes the offset DAC from bias; DC to DC keeps it.
// - Trim codes step the offset DAC up or down.
// - Leave-trim ends adjustment and sets DC coupling.
// - Offset values are saved at power-down and restored at power-up.
// - Coupling needs the variable fixed-step gain option.
// - Tone select: 0 off, 1 is 1000 Hz, 2 is 100 Hz.
// - Tone on forces charge mode and injects 100pC; current modes use 1mV/pC.
// - Tone needs the isolation module.
// - Descriptor read checks the application register status first, reads it if full.
// - Descriptor reply: presence flag, 8 application bytes if present, 32 memory bytes.
// - Descriptor data returned raw; query only, one specific channel.
// - Combined read is query only, specific channel, returns labelled settings.
// - Bias read is global query, all channels' bias levels.
// - Status read is global query, unit map then one map per channel.
// - Commands carry unit and channel; zero means global.
// - Nothing is answered for a command to all units.
// - Failures answer with a negative code, -1 to -6.
// - Channel fault map bits low on short, open, overload; 7 means clean.
module csci_interp
  import csci_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter logic [7:0] FIRST_CH = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire csci_pkg::csci_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output csci_pkg::csci_rsp_t rsp,
  input wire logic rsp_ready,
  input wire logic power_down,
  input wire logic [NCH*DAC_W-1:0] nv_offsets,
  output logic [NCH*DAC_W-1:0] nv_store_data,
  output logic nv_store,
  input wire logic [NCH*BIAS_W-1:0] bias_levels,
  input wire logic [NCH*3-1:0] chan_faults,
  output logic desc_req,
  output logic [CH_W-1:0] desc_chan,
  input wire logic desc_done,
  input wire logic desc_app_full,
  output logic [NCH-1:0] tone_inject,
  output logic [NCH*DAC_W-1:0] offset_dac,
  output logic [NCH*$bits(csci_chan_t)-1:0] chan_cfg,
  output logic [4:0] excitation_current_level
);
  import csci_pkg::*;

  localparam logic [11:0] REG_OPTIONS = 12'h000;
  localparam logic [11:0] REG_UNIT_ID = 12'h004;
  localparam logic [11:0] REG_UNIT_STATUS = 12'h008;
  localparam logic [11:0] REG_STATE = 12'h00c;
  localparam logic [7:0] UNIT_ID_DEF = 8'h01;

  typedef enum logic [1:0] {CSCI_IDLE, CSCI_DESC_WAIT, CSCI_ANSWER} csci_state_t;

  csci_state_t state_q;
  csci_chan_t ch_q [NCH];
  logic [4:0] excitation_current_level_q;
  logic [7:0] unit_id_q;
  logic opt_var_gain_q;
  logic opt_isolation_q;
  logic [2:0] unit_status_q;
  logic restore_q;
  csci_cmd_t cur_q;
  logic [NCH-1:0] zero_q, up_q, down_q;
  logic [NCH*DAC_W-1:0] dac_w;
  csci_err_t err_d;
  logic silent_d;

  // Channel index from a 1-based channel number
  function automatic int ch_idx(input logic [CH_W-1:0] c);
    return int'(c) - 1;
  endfunction

  function automatic logic ch_ok(input logic [CH_W-1:0] c);
    return c != '0 && int'(c) <= NCH;
  endfunction

  // APB slave, zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      unit_id_q <= UNIT_ID_DEF;
      opt_var_gain_q <= 1'b0;
      opt_isolation_q <= 1'b0;
      unit_status_q <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        unique case (paddr)
          REG_OPTIONS: begin
            if (pwrite) begin
              opt_var_gain_q <= pwdata[0];
              opt_isolation_q <= pwdata[1];
            end
            prdata <= {30'h0, opt_isolation_q, opt_var_gain_q};
          end
          REG_UNIT_ID: begin
            if (pwrite) begin
              unit_id_q <= pwdata[7:0];
            end
            prdata <= {24'h0, unit_id_q};
          end
          REG_UNIT_STATUS: begin
            if (pwrite) begin
              unit_status_q <= pwdata[2:0];
            end
            prdata <= 32'({chan_faults, unit_status_q});
          end
          REG_STATE: begin
            prdata <= {22'h0, state_q, excitation_current_level_q, 3'h0};
            pslverr <= pwrite;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Validity and error classification of the command in hand
  always_comb begin
    err_d = CSCI_OK;
    silent_d = cmd.unit == 8'h00;
    if (cmd.unit != unit_id_q && !silent_d) begin
      err_d = CSCI_E_UNIT;
    end else if (cmd.op == CSCI_OP_OTHER) begin
      err_d = CSCI_E_COMMAND;
    end else if (int'(cmd.chan) > NCH) begin
      err_d = CSCI_E_CHANNEL;
    end else if ((cmd.op == CSCI_OP_DESC_READ || cmd.op == CSCI_OP_COMBINED)
                 && cmd.chan == '0) begin
      err_d = CSCI_E_CHANNEL;
    end else if (!cmd.query && (cmd.op == CSCI_OP_DESC_READ || cmd.op == CSCI_OP_COMBINED
                 || cmd.op == CSCI_OP_BIAS || cmd.op == CSCI_OP_STATUS)) begin
      err_d = CSCI_E_FUNCTION;
    end else if (cmd.op == CSCI_OP_COUPLING && !opt_var_gain_q) begin
      err_d = CSCI_E_OPTION;
    end else if (cmd.op == CSCI_OP_TONE && !opt_isolation_q) begin
      err_d = CSCI_E_OPTION;
    end else if (!cmd.query && !cmd.has_value) begin
      err_d = CSCI_E_OPTION;
    end else if (!cmd.query) begin
      unique case (cmd.op)
        CSCI_OP_INPUT_MODE: if (cmd.value > 8'(MODE_MAX)) err_d = CSCI_E_PARAM;
        CSCI_OP_EXCITATION: if (cmd.value > 8'(EXCITATION_CURRENT_LEVEL_MAX)) err_d = CSCI_E_PARAM;
        CSCI_OP_IN_FILTER, CSCI_OP_OUT_FILTER, CSCI_OP_LIMIT:
          if (cmd.value > 8'h01) err_d = CSCI_E_PARAM;
        CSCI_OP_COUPLING: if (cmd.value > 8'(CPL_LEAVE)) err_d = CSCI_E_PARAM;
        CSCI_OP_TONE: if (cmd.value > 8'(OSC_MAX)) err_d = CSCI_E_PARAM;
        default: err_d = CSCI_OK;
      endcase
    end
  end

  assign cmd_ready = state_q == CSCI_IDLE;

  // Command sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CSCI_IDLE;
      cur_q <= '0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      desc_req <= 1'b0;
      desc_chan <= '0;
    end else begin
      desc_req <= 1'b0;
      unique case (state_q)
        CSCI_IDLE: begin
          if (cmd_valid) begin
            cur_q <= cmd;
            rsp.unit <= cmd.unit;
            rsp.op <= cmd.op;
            rsp.err <= err_d;
            rsp.all_chan <= cmd.chan == '0 || cmd.op == CSCI_OP_BIAS
                            || cmd.op == CSCI_OP_STATUS;
            // Unit-wide value reports the board's first channel
            rsp.chan <= (cmd.op == CSCI_OP_EXCITATION) ? CH_W'(FIRST_CH) : cmd.chan;
            rsp.value <= (cmd.op == CSCI_OP_EXCITATION) ? {3'h0, excitation_current_level_q} : 8'h00;
            if (cmd.query && ch_ok(cmd.chan)) begin
              unique case (cmd.op)
                CSCI_OP_INPUT_MODE: rsp.value <= {4'h0, ch_q[ch_idx(cmd.chan)].mode};
                CSCI_OP_IN_FILTER: rsp.value <= {7'h0, ch_q[ch_idx(cmd.chan)].in_filt};
                CSCI_OP_OUT_FILTER: rsp.value <= {7'h0, ch_q[ch_idx(cmd.chan)].out_filt};
                CSCI_OP_LIMIT: rsp.value <= {7'h0, ch_q[ch_idx(cmd.chan)].limit};
                CSCI_OP_COUPLING: rsp.value <= {5'h0, ch_q[ch_idx(cmd.chan)].coupling};
                CSCI_OP_TONE: rsp.value <= {6'h0, ch_q[ch_idx(cmd.chan)].tone};
                default: ;
              endcase
            end
            if (silent_d) begin
              state_q <= CSCI_IDLE;
            end else if (err_d == CSCI_OK && cmd.op == CSCI_OP_DESC_READ) begin
              desc_req <= 1'b1;
              desc_chan <= cmd.chan;
              state_q <= CSCI_DESC_WAIT;
            end else begin
              rsp_valid <= 1'b1;
              state_q <= CSCI_ANSWER;
            end
          end
        end
        CSCI_DESC_WAIT: begin
          if (desc_done) begin
            // Presence flag then raw bytes; formatter streams 8+32 or 32 bytes
            rsp.value <= desc_app_full ? DESC_MAX : MEM_BYTES;
            rsp_valid <= 1'b1;
            state_q <= CSCI_ANSWER;
          end
        end
        CSCI_ANSWER: begin
          if (rsp_ready) begin
            rsp_valid <= 1'b0;
            state_q <= CSCI_IDLE;
          end
        end
      endcase
    end
  end

  wire accept = state_q == CSCI_IDLE && cmd_valid && err_d == CSCI_OK && !cmd.query;

  // Per-channel settings and excitation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excitation_current_level_q <= EXCITATION_CURRENT_LEVEL_DEF;
      for (int i = 0; i < NCH; i++) begin
        ch_q[i] <= '{mode: MODE_DEF, in_filt: 1'b0, out_filt: 1'b0, limit: 1'b0,
                     coupling: CPL_AC, tone: 2'h0};
      end
      zero_q <= '0;
      up_q <= '0;
      down_q <= '0;
    end else begin
      zero_q <= '0;
      up_q <= '0;
      down_q <= '0;
      if (accept) begin
        for (int i = 0; i < NCH; i++) begin
          if (cmd.op == CSCI_OP_EXCITATION) begin
            if (cmd.value != 8'h00 && ch_q[i].mode == MODE_VOLT) begin
              ch_q[i].mode <= MODE_CCS;
            end else if (cmd.value == 8'h00 && ch_q[i].mode == MODE_CCS) begin
              ch_q[i].mode <= MODE_VOLT;
            end
          end else if (cmd.chan == '0 || ch_idx(cmd.chan) == i) begin
            unique case (cmd.op)
              CSCI_OP_INPUT_MODE: ch_q[i].mode <= cmd.value[3:0];
              CSCI_OP_IN_FILTER: ch_q[i].in_filt <= cmd.value[0];
              CSCI_OP_OUT_FILTER: ch_q[i].out_filt <= cmd.value[0];
              CSCI_OP_LIMIT: ch_q[i].limit <= cmd.value[0];
              CSCI_OP_COUPLING: begin
                unique case (cmd.value[2:0])
                  CPL_AC: ch_q[i].coupling <= CPL_AC;
                  CPL_DC: begin
                    ch_q[i].coupling <= CPL_DC;
                    zero_q[i] <= ch_q[i].coupling == CPL_AC;
                  end
                  CPL_UP: up_q[i] <= 1'b1;
                  CPL_DOWN: down_q[i] <= 1'b1;
                  default: ch_q[i].coupling <= CPL_DC;
                endcase
              end
              CSCI_OP_TONE: begin
                ch_q[i].tone <= cmd.value[1:0];
                if (cmd.value != 8'h00) begin
                  ch_q[i].mode <= MODE_CHARGE;
                end
              end
              default: ;
            endcase
          end
        end
        if (cmd.op == CSCI_OP_EXCITATION) begin
          excitation_current_level_q <= cmd.value[4:0];
        end
      end
    end
  end

  // Restore offsets one cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_q <= 1'b1;
    end else begin
      restore_q <= 1'b0;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_trim
    csci_offset_trim #(.W(DAC_W)) u_trim (
      .pclk(pclk),
      .presetn(presetn),
      .restore(restore_q),
      .saved_value(nv_offsets[g*DAC_W +: DAC_W]),
      .zero_load(zero_q[g]),
      .bias(bias_levels[g*BIAS_W +: BIAS_W]),
      .step_up(up_q[g]),
      .step_down(down_q[g]),
      .dac_q(dac_w[g*DAC_W +: DAC_W])
    );
  end

  // Registered outputs to the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_store <= 1'b0;
      nv_store_data <= '0;
      tone_inject <= '0;
      offset_dac <= '0;
      chan_cfg <= '0;
      excitation_current_level <= '0;
    end else begin
      nv_store <= power_down;
      if (power_down) begin
        nv_store_data <= dac_w;
      end
      offset_dac <= dac_w;
      excitation_current_level <= excitation_current_level_q;
      for (int i = 0; i < NCH; i++) begin
        tone_inject[i] <= ch_q[i].tone != 2'h0;
        chan_cfg[i*$bits(csci_chan_t) +: $bits(csci_chan_t)] <= ch_q[i];
      end
    end
  end
endmodule

// ### dv/csci_host_model.sv
// Host model: offers one parsed command at a time and collects the answer.
// Assumes commands are taken on cmd_valid and cmd_ready at a rising edge.
module csci_host_model
  import csci_pkg::*;
(
  input wire logic pclk,
  output logic cmd_valid,
  output csci_pkg::csci_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csci_pkg::csci_rsp_t rsp,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int slow = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b0;
  end
  // Whole command held until taken, then scrambled
  task automatic xfer(input csci_cmd_t c, input int lim, output csci_rsp_t r,
                      output bit got);
    int n;
    got = 1'b0;
    r = '0;
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd <= c;
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      if (cmd_ready) break;
    end
    cmd_valid <= 1'b0;
    cmd <= ~c;
    for (n = 0; n < lim && !got; n++) begin
      @(posedge pclk);
      if (rsp_valid) begin
        got = 1'b1;
        r = rsp;
      end
    end
    if (got) begin
      repeat (slow) @(posedge pclk);
      rsp_ready <= 1'b1;
      @(posedge pclk);
      rsp_ready <= 1'b0;
    end
  endtask
endmodule

// ### dv/csci_interp_assertions.sv
// Checker for the command interpreter: answer timing and mode side effects.
// Assumes one clock domain; bound to csci_interp after the module.
module csci_interp_assertions
  import csci_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cmd_valid,
  input wire csci_pkg::csci_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csci_pkg::csci_rsp_t rsp,
  input wire logic rsp_ready,
  input wire logic power_down,
  input wire logic nv_store,
  input wire logic desc_done,
  input wire logic desc_app_full,
  input wire logic [NCH-1:0] tone_inject,
  input wire logic [NCH*$bits(csci_chan_t)-1:0] chan_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = $bits(csci_chan_t);
  logic any_volt, any_ccs, bad_tone, take;
  csci_chan_t c;
  assign take = cmd_valid && cmd_ready;
  always_comb begin
    any_volt = 1'b0;
    any_ccs = 1'b0;
    bad_tone = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      c = chan_cfg[i*CW +: CW];
      any_volt |= c.mode == MODE_VOLT;
      any_ccs |= c.mode == MODE_CCS;
      bad_tone |= tone_inject[i] && (c.mode inside {MODE_VOLT, MODE_CCS, MODE_ISO_CCS});
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("answer changed before accepted");
  no_global_a: assert property (take && cmd.unit == 8'h00 |=> !rsp_valid [*8])
    else $error("answer to all-unit command");
  answer_next_a: assert property (take && cmd.unit != 8'h00 && cmd.op != CSCI_OP_DESC_READ
    |=> rsp_valid)
    else $error("no answer one cycle after command");
  exc_on_a: assert property (take && cmd.op == CSCI_OP_EXCITATION && !cmd.query
    && (cmd.value inside {[8'h01:8'h14]}) ##1 rsp_valid && rsp.err == CSCI_OK |=> !any_volt)
    else $error("voltage mode left with excitation on");
  exc_off_a: assert property (take && cmd.op == CSCI_OP_EXCITATION && !cmd.query
    && cmd.value == 8'h00 ##1 rsp_valid && rsp.err == CSCI_OK |=> !any_ccs)
    else $error("current mode left with excitation off");
  tone_charge_a: assert property (!bad_tone)
    else $error("tone injected outside charge mode");
  desc_len_a: assert property (desc_done |=> rsp_valid
    && rsp.value == ($past(desc_app_full) ? DESC_MAX : MEM_BYTES))
    else $error("descriptor byte count wrong");
  nv_keep_a: assert property ($rose(power_down) |=> nv_store)
    else $error("offsets not stored at power-down");
  cover property (take && cmd.op == CSCI_OP_COUPLING);
  cover property (desc_done && desc_app_full);
  cover property (rsp_valid && !rsp_ready ##1 rsp_valid);
endmodule

bind csci_interp csci_interp_assertions #(.NCH(NCH)) u_csci_interp_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .rsp_ready(rsp_ready), .power_down(power_down), .nv_store(nv_store),
  .desc_done(desc_done), .desc_app_full(desc_app_full), .tone_inject(tone_inject),
  .chan_cfg(chan_cfg)
);

// ### dv/csci_interp_tb.sv
// Testbench for the command interpreter: options, channel settings, zeroing, descriptor.
// Assumes the host model sends commands; descriptor memory is answered here.
module csci_interp_tb
  import csci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, power_down = 0;
  logic pready, pslverr, cmd_valid, cmd_ready, rsp_valid, rsp_ready, nv_store, desc_req, er;
  logic desc_done = 0, desc_app_full = 0, app_full = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [47:0] nv_offsets = 48'h123_456_789_abc, bias_levels = {4{12'h900}};
  logic [47:0] nv_store_data, offset_dac;
  logic [51:0] chan_cfg;
  logic [3:0] tone_inject;
  logic [4:0] excitation_current_level;
  logic [2:0] desc_chan;
  logic [11:0] chan_faults = 12'hff5;
  csci_cmd_t cmd;
  csci_rsp_t rsp, r;
  int fails = 0, n_checks = 0;
  bit got;
  event hang;

  csci_interp u_csci_interp (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .rsp_ready(rsp_ready), .power_down(power_down), .nv_offsets(nv_offsets),
    .nv_store_data(nv_store_data), .nv_store(nv_store), .bias_levels(bias_levels),
    .chan_faults(chan_faults), .desc_req(desc_req), .desc_chan(desc_chan),
    .desc_done(desc_done), .desc_app_full(desc_app_full), .tone_inject(tone_inject),
    .offset_dac(offset_dac), .chan_cfg(chan_cfg),
    .excitation_current_level(excitation_current_level)
  );
  csci_host_model u_csci_host_model (
    .pclk(pclk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready)
  );

  always #4 pclk = ~pclk;
  // Descriptor memory answers one cycle after the request
  always @(posedge pclk) begin
    desc_done <= desc_req;
    desc_app_full <= app_full;
  end

  task automatic chk(string n, logic [47:0] s, logic [47:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready) break;
    end
    if (n == 50) -> hang;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(csci_op_t op, logic [2:0] ch, logic q, logic [7:0] v, logic [7:0] u = 1);
    csci_cmd_t c;
    c = '{u, ch, op, q, !q, v};
    u_csci_host_model.xfer(c, (u == 0) ? 10 : 50, r, got);
    if (!got && u != 0) begin
      fails++;
      -> hang;
    end
  endtask
  task automatic gc(csci_op_t op, logic [2:0] ch, logic q, logic [7:0] v, csci_err_t e,
                    logic [7:0] x = 0);
    go(op, ch, q, v);
    chk({op.name(), " err"}, r.err, e);
    chk({op.name(), " unit"}, r.unit, 1);
    if (q) chk({op.name(), " value"}, r.value, x);
  endtask

  task automatic t_reset();
    chk("restored dac", offset_dac, nv_offsets);
    apb(0, 12'h004, 0);
    chk("unit id", rd, 1);
    apb(1, 12'h00c, 0);
    chk("ro write err", er, 1);
    apb(0, 12'h010, 0);
    chk("unmapped err", er, 1);
    apb(0, 12'h008, 0);
    chk("fault map", rd, {chan_faults, 3'h0});
    gc(CSCI_OP_COUPLING, 1, 0, 1, CSCI_E_OPTION);
    apb(1, 12'h000, 1);
    gc(CSCI_OP_TONE, 1, 0, 1, CSCI_E_OPTION);
    apb(1, 12'h000, 3);
    apb(0, 12'h000, 0);
    chk("options", rd, 3);
    $display("reset test done");
  endtask
  task automatic t_mode();
    for (int m = 0; m <= 9; m++) begin
      gc(CSCI_OP_INPUT_MODE, 1, 0, 8'(m), CSCI_OK);
      gc(CSCI_OP_INPUT_MODE, 1, 1, 0, CSCI_OK, 8'(m));
    end
    gc(CSCI_OP_INPUT_MODE, 1, 0, 8'h0a, CSCI_E_PARAM);
    gc(CSCI_OP_INPUT_MODE, 1, 1, 0, CSCI_OK, 8'h09);
    gc(CSCI_OP_INPUT_MODE, 1, 0, 1, CSCI_OK);
    gc(CSCI_OP_INPUT_MODE, 2, 0, 2, CSCI_OK);
    gc(CSCI_OP_EXCITATION, 3, 0, 0, CSCI_OK);
    gc(CSCI_OP_INPUT_MODE, 2, 1, 0, CSCI_OK, MODE_VOLT);
    gc(CSCI_OP_EXCITATION, 4, 0, 8'h14, CSCI_OK);
    gc(CSCI_OP_INPUT_MODE, 1, 1, 0, CSCI_OK, MODE_CCS);
    gc(CSCI_OP_INPUT_MODE, 2, 1, 0, CSCI_OK, MODE_CCS);
    gc(CSCI_OP_EXCITATION, 1, 0, 8'h15, CSCI_E_PARAM);
    gc(CSCI_OP_EXCITATION, 3, 1, 0, CSCI_OK, 8'h14);
    chk("unit chan", r.chan, 1);
    chk("exc level", excitation_current_level, 5'h14);
    $display("mode test done");
  endtask
  task automatic t_filt();
    csci_op_t ops[3] = '{CSCI_OP_IN_FILTER, CSCI_OP_OUT_FILTER, CSCI_OP_LIMIT};
    foreach (ops[i]) begin
      gc(ops[i], 1, 0, 1, CSCI_OK);
      gc(ops[i], 1, 1, 0, CSCI_OK, 1);
      gc(ops[i], 2, 1, 0, CSCI_OK, 0);
      gc(ops[i], 1, 0, 2, CSCI_E_PARAM);
      gc(ops[i], 1, 1, 0, CSCI_OK, 1);
      gc(ops[i], 1, 0, 0, CSCI_OK);
      gc(ops[i], 1, 1, 0, CSCI_OK, 0);
    end
    $display("filter test done");
  endtask
  task automatic t_cpl();
    u_csci_host_model.slow = 3;
    gc(CSCI_OP_COUPLING, 0, 0, 1, CSCI_OK);
    chk("zeroed", offset_dac, {4{12'h700}});
    gc(CSCI_OP_COUPLING, 0, 0, 2, CSCI_OK);
    chk("trim up", offset_dac, {4{12'h701}});
    gc(CSCI_OP_COUPLING, 0, 0, 3, CSCI_OK);
    gc(CSCI_OP_COUPLING, 0, 0, 3, CSCI_OK);
    chk("trim down", offset_dac, {4{12'h6ff}});
    gc(CSCI_OP_COUPLING, 0, 0, 4, CSCI_OK);
    gc(CSCI_OP_COUPLING, 2, 1, 0, CSCI_OK, CPL_DC);
    gc(CSCI_OP_COUPLING, 0, 0, 1, CSCI_OK);
    chk("kept", offset_dac, {4{12'h6ff}});
    u_csci_host_model.slow = 0;
    gc(CSCI_OP_COUPLING, 1, 0, 5, CSCI_E_PARAM);
    gc(CSCI_OP_COUPLING, 1, 0, 0, CSCI_OK);
    gc(CSCI_OP_COUPLING, 1, 1, 0, CSCI_OK, CPL_AC);
    power_down <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("store", nv_store, 1);
    chk("store data", nv_store_data, {4{12'h6ff}});
    power_down <= 1'b0;
    $display("coupling test done");
  endtask
  task automatic t_tone();
    for (int t = 2; t >= 0; t--) begin
      gc(CSCI_OP_TONE, 1, 0, 8'(t), CSCI_OK);
      chk("inject", |tone_inject, t != 0);
      gc(CSCI_OP_TONE, 1, 1, 0, CSCI_OK, 8'(t));
    end
    gc(CSCI_OP_TONE, 1, 0, 3, CSCI_E_PARAM);
    $display("tone test done");
  endtask
  task automatic t_read();
    for (int f = 0; f < 2; f++) begin
      app_full <= f[0];
      gc(CSCI_OP_DESC_READ, 2, 1, 0, CSCI_OK, f ? DESC_MAX : MEM_BYTES);
      chk("desc chan", desc_chan, 2);
    end
    gc(CSCI_OP_DESC_READ, 2, 0, 1, CSCI_E_FUNCTION);
    gc(CSCI_OP_COMBINED, 0, 1, 0, CSCI_E_CHANNEL);
    gc(CSCI_OP_COMBINED, 1, 0, 0, CSCI_E_FUNCTION);
    gc(CSCI_OP_BIAS, 3, 0, 0, CSCI_E_FUNCTION);
    gc(CSCI_OP_STATUS, 3, 0, 0, CSCI_E_FUNCTION);
    go(CSCI_OP_BIAS, 3, 1, 0);
    chk("bias all", r.all_chan, 1);
    go(CSCI_OP_STATUS, 2, 1, 0);
    chk("status all", r.all_chan, 1);
    go(CSCI_OP_IN_FILTER, 1, 0, 1, 8'h07);
    chk("unit err", r.err, CSCI_E_UNIT);
    go(CSCI_OP_IN_FILTER, 1, 0, 1, 8'h00);
    chk("silent", got, 0);
    gc(CSCI_OP_IN_FILTER, 1, 1, 0, CSCI_OK, 1);
    $display("read test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_mode();
    t_filt();
    t_cpl();
    t_tone();
    t_read();
    end_of_test();
  end
  initial begin
    @(hang);
    fails++;
    end_of_test();
  end
endmodule
